// ### bbs_host.sv
`timescale 1ns/10ps
module bbs_host
  import bbs_pkg::*;
#(
  parameter int REC_CYCLES = RECOVERY_CYC,
  parameter int REC_W = $clog2(REC_CYCLES + 1)
)
(
  input wire logic clock, // 20 MHz host clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic req, // Access request, level
  input wire logic req_wr, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr, // Byte address
  input wire logic [DATA_W-1:0] req_wdata, // Write data
  output logic ready, // Accepting a request
  output logic done, // One-cycle pulse at end of access
  output logic [DATA_W-1:0] rdata, // Last read data
  output logic battery_low_flag, // Battery check failed
  input wire logic power_fail, // Supply monitor, high when failing
  output logic chip_sel_n, // Memory chip select
  output logic gate_n, // Memory output gate
  output logic strobe_n, // Memory write strobe
  output logic [ADDR_W-1:0] mem_addr, // Memory address lines
  output logic [DATA_W-1:0] data_lines_out, // Data lines, driven value
  output logic data_lines_oe, // Data lines driven when high
  input wire logic [DATA_W-1:0] data_lines_in // Data lines, sensed
);

  logic rst_s1_reg;
  logic rst_n;
  bbs_pin_if pins ();

  bbs_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [REC_W-1:0] rec_reg, rec_next;
  logic [2:0] chk_reg, chk_next;
  logic op_wr_reg, op_wr_next;
  logic op_user_reg, op_user_next;
  logic [ADDR_W-1:0] op_addr_reg, op_addr_next;
  logic [DATA_W-1:0] op_data_reg, op_data_next;
  logic [DATA_W-1:0] orig_reg;
  logic start_op;
  logic capture;
  logic op_end;

  // Reset released through two flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Power-fail and read data are pins from outside the clock domain
  bbs_pin_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .data_pin(data_lines_in),
    .pf_pin(power_fail),
    .pins(pins)
  );

  // Sequencer: next state, counters and the operation in flight
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rec_next = rec_reg;
    chk_next = chk_reg;
    op_wr_next = op_wr_reg;
    op_user_next = op_user_reg;
    op_addr_next = op_addr_reg;
    op_data_next = op_data_reg;
    start_op = 1'b0;
    capture = 1'b0;
    op_end = (state_reg == S_HOLD) && (cnt_reg == 4'h0);
    case (state_reg)
      S_RECOVER:
      begin
        if (rec_reg == '0)
        begin
          state_next = S_IDLE;
        end
        else
        begin
          rec_next = rec_reg - 1'b1;
        end
      end
      S_IDLE:
      begin
        if (chk_reg != CHK_DONE)
        begin
          // Battery check: read, write inverse, read back, restore
          start_op = 1'b1;
          op_user_next = 1'b0;
          op_wr_next = chk_reg[0];
          op_addr_next = CHECK_ADDR;
          op_data_next = (chk_reg == 3'h1) ? ~orig_reg : orig_reg;
        end
        else if (req)
        begin
          start_op = 1'b1;
          op_user_next = 1'b1;
          op_wr_next = req_wr;
          op_addr_next = req_addr;
          op_data_next = req_wdata;
        end
        if (start_op)
        begin
          state_next = op_wr_next ? S_WRITE : S_READ;
          cnt_next = op_wr_next ? STROBE_CYC - 4'h1 : RD_CYC - 4'h1;
        end
      end
      S_READ:
      begin
        if (cnt_reg == 4'h0)
        begin
          capture = 1'b1;
          state_next = S_HOLD;
          cnt_next = FLOAT_CYC - 4'h1;
        end
        else
        begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      S_WRITE:
      begin
        if (cnt_reg == 4'h0)
        begin
          state_next = S_HOLD;
          cnt_next = HOLD_CYC - 4'h1;
        end
        else
        begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      S_HOLD:
      begin
        if (op_end)
        begin
          state_next = S_IDLE;
          if (!op_user_reg)
          begin
            chk_next = chk_reg + 3'h1;
          end
        end
        else
        begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default:
      begin
        state_next = S_RECOVER;
      end
    endcase
    // Power fail aborts anything, restarts the wait and the check
    if (pins.pf_q)
    begin
      state_next = S_RECOVER;
      rec_next = REC_W'(REC_CYCLES);
      chk_next = CHK_FIRST;
      start_op = 1'b0;
      capture = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= S_RECOVER;
      cnt_reg <= 4'h0;
      rec_reg <= REC_W'(REC_CYCLES);
      chk_reg <= CHK_FIRST;
      op_wr_reg <= 1'b0;
      op_user_reg <= 1'b0;
      op_addr_reg <= '0;
      op_data_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rec_reg <= rec_next;
      chk_reg <= chk_next;
      op_wr_reg <= op_wr_next;
      op_user_reg <= op_user_next;
      op_addr_reg <= op_addr_next;
      op_data_reg <= op_data_next;
    end
  end

  // Memory pins follow the next state so every pin is a flop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_sel_n <= 1'b1;
      gate_n <= 1'b1;
      strobe_n <= 1'b1;
      mem_addr <= '0;
      data_lines_out <= '0;
      data_lines_oe <= 1'b0;
    end
    else
    begin
      chip_sel_n <= !((state_next == S_READ) || (state_next == S_WRITE));
      gate_n <= !(state_next == S_READ);
      strobe_n <= !(state_next == S_WRITE);
      mem_addr <= op_addr_next;
      data_lines_out <= op_data_next;
      data_lines_oe <= (state_next == S_WRITE)
                       || ((state_next == S_HOLD) && op_wr_next);
    end
  end

  // User-side answers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      ready <= (state_next == S_IDLE) && (chk_next == CHK_DONE);
      done <= op_end && op_user_reg && !pins.pf_q;
      if (capture && op_user_reg)
      begin
        rdata <= pins.data_q;
      end
    end
  end

  // Battery check: a swallowed write leaves the old byte in place
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      orig_reg <= '0;
      battery_low_flag <= 1'b0;
    end
    else if (capture && !op_user_reg)
    begin
      if (chk_reg == CHK_FIRST)
      begin
        orig_reg <= pins.data_q;
      end
      else if (chk_reg == CHK_READBACK)
      begin
        battery_low_flag <= (pins.data_q != ~orig_reg);
      end
    end
  end

  // Checks on the pins this block drives
  sequence strobe_low_s;
    !strobe_n [*2];
  endsequence

  sequence gate_low_s;
    !gate_n [*7];
  endsequence

  strobe_width_a: assert property (
    @(posedge clock) disable iff (!rst_n || pins.pf_q)
    $fell(strobe_n) |-> strobe_low_s)
    else $error("write strobe pulse too short");

  read_wait_a: assert property (
    @(posedge clock) disable iff (!rst_n || pins.pf_q)
    $fell(gate_n) |-> gate_low_s ##1 gate_n)
    else $error("read gate length wrong");

  write_addr_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !strobe_n |=> $stable(mem_addr))
    else $error("address moved during write");

  gate_in_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !strobe_n |-> gate_n && data_lines_oe)
    else $error("gate low or data undriven in write");

  data_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n || pins.pf_q)
    $rose(strobe_n) |-> data_lines_oe && $stable(data_lines_out)
                        && $stable(mem_addr))
    else $error("data or address not held after write");

  joint_fall_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(strobe_n) |-> $fell(chip_sel_n))
    else $error("strobe and select fell apart");

  no_contend_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    data_lines_oe |-> gate_n ##1 (gate_n || !$past(data_lines_oe)))
    else $error("bus contention with memory outputs");

  turnaround_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(gate_n) |-> !data_lines_oe)
    else $error("bus driven right after read");

  pf_deselect_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    pins.pf_q |=> chip_sel_n && strobe_n && !data_lines_oe && !ready)
    else $error("access during power fail");

  recovery_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_reg == S_RECOVER) && (rec_reg != '0)
      |=> (state_reg == S_RECOVER) && chip_sel_n)
    else $error("recovery left early or select during recovery");

endmodule : bbs_host

// ### bbs_pkg.sv
package bbs_pkg;

  // Host clock
  localparam int CLK_PERIOD_NS = 50;

  // Memory geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // Device timing, slower grade where two grades differ
  localparam int ADDR_ACCESS_TIME_NS = 100;
  localparam int GATE_ACCESS_TIME_NS = 50;
  localparam int FLOAT_TIME_NS = 50;
  localparam int STROBE_WIDTH_NS = 80;
  localparam int DATA_SETUP_TIME_NS = 50;
  localparam int DATA_HOLD_TIME_NS = 5;
  localparam int ADDR_HOLD_TIME_NS = 10;
  localparam int RECOVERY_DELAY_MS = 200;

  // Least time in ns to whole clock cycles, never below one
  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c;
  endfunction : ns_up

  // Latency of the three-stage pin input filter
  localparam int SYNC_LAT = 4;

  // Cycle counts derived from the times above
  localparam logic [3:0] ACC_CYC = 4'(ns_up(ADDR_ACCESS_TIME_NS));
  localparam logic [3:0] RD_CYC = 4'(ns_up(ADDR_ACCESS_TIME_NS)
                                     + SYNC_LAT + 1);
  localparam logic [3:0] STROBE_CYC = 4'(ns_up(STROBE_WIDTH_NS));
  localparam logic [3:0] FLOAT_CYC = 4'(ns_up(FLOAT_TIME_NS));
  localparam logic [3:0] HOLD_CYC = 4'(ns_up(ADDR_HOLD_TIME_NS));
  localparam int RECOVERY_CYC = RECOVERY_DELAY_MS * 1000000
                                / CLK_PERIOD_NS;

  // Battery check sequence
  localparam logic [ADDR_W-1:0] CHECK_ADDR = 15'h0000;
  localparam logic [2:0] CHK_FIRST = 3'h0;
  localparam logic [2:0] CHK_READBACK = 3'h2;
  localparam logic [2:0] CHK_DONE = 3'h4;

  typedef enum logic [2:0] {
    S_RECOVER = 3'b000,
    S_IDLE    = 3'b001,
    S_READ    = 3'b010,
    S_WRITE   = 3'b011,
    S_HOLD    = 3'b100
  } bbs_state_t;

endpackage : bbs_pkg

// ### bbs_pin_if.sv
`timescale 1ns/10ps
interface bbs_pin_if;
  logic [7:0] data_q;
  logic pf_q;
  modport sync (output data_q, output pf_q);
  modport user (input data_q, input pf_q);
endinterface : bbs_pin_if

// ### bbs_pin_sync.sv
`timescale 1ns/10ps
module bbs_pin_sync
  import bbs_pkg::*;
(
  input wire logic clock, // Host clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [DATA_W-1:0] data_pin, // Data lines from the memory
  input wire logic pf_pin, // Power-fail level from supply monitor
  bbs_pin_if.sync pins // Filtered copies
);

  logic [DATA_W:0] s1_reg;
  logic [DATA_W:0] s2_reg;
  logic [DATA_W:0] s3_reg;
  logic [DATA_W:0] q_reg;

  // Three stages; the first is read only by the second
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 9'h100;
      s2_reg <= 9'h100;
      s3_reg <= 9'h100;
    end
    else
    begin
      s1_reg <= {pf_pin, data_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_reg <= 9'h100; // Assume power failing until seen otherwise
    end
    else if (s2_reg == s3_reg)
    begin
      q_reg <= s2_reg;
    end
  end

  assign pins.data_q = q_reg[DATA_W-1:0];
  assign pins.pf_q = q_reg[DATA_W];

endmodule : bbs_pin_sync

// ### bbs_sram_model.sv
`timescale 1ns/10ps
module bbs_sram_model
  import bbs_pkg::*;
(
  input wire logic pwr_up, // Rises when the supply becomes valid
  input wire logic bat_low_in, // Battery below its good level
  input wire logic pf, // Supply failing
  input wire logic cs_n, // Chip select
  input wire logic g_n, // Output gate
  input wire logic w_n, // Write strobe
  input wire logic [ADDR_W-1:0] a, // Address lines
  input wire logic [DATA_W-1:0] d, // Sensed data lines
  output logic [DATA_W-1:0] q // Value the memory puts on the lines
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] drv_q;
  logic [DATA_W-1:0] flt_q;
  logic bat_flag;
  logic en;
  logic wr;
  // Drive only in read mode; a falling strobe or power fail cuts it
  assign en = !pf && !cs_n && !g_n && w_n;
  assign wr = !cs_n && !w_n;
  // Released lines show the inverse of the last value, never a held copy
  assign q = en ? drv_q : flt_q;
  // Known contents so every readback can be predicted
  initial
  begin
    for (int i = 0; i < 32768; i++)
    begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    flt_q = 8'h00;
    drv_q = 8'h00;
    bat_flag = 1'b0;
  end
  // Junk until the address access time has run, then the byte
  always @(posedge en or a)
  begin
    if (en)
    begin
      drv_q = ~mem[a];
      drv_q <= #(ADDR_ACCESS_TIME_NS) mem[a];
    end
  end
  always @(negedge en)
  begin
    flt_q = ~drv_q;
  end
  // Write lands at the earlier rising edge of select or strobe
  always @(negedge wr)
  begin
    if (!pf && pwr_up)
    begin
      if (bat_flag)
      begin
        bat_flag = 1'b0;
      end
      else
      begin
        mem[a] = d;
      end
    end
  end
  // Battery looked at once, as the supply comes back
  always @(posedge pwr_up)
  begin
    bat_flag = bat_low_in;
  end
endmodule : bbs_sram_model

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import bbs_pkg::*;
  localparam int REC = 20;
  logic clock, rstn, req, req_wr, power_fail, bat_low, ready, done;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rdata, data_lines_out, mdl_q, bus;
  logic battery_low_flag, chip_sel_n, gate_n, strobe_n, data_lines_oe;
  int failures, tests_run;
  // Host wins while enabled, else the memory or its float pattern
  assign bus = data_lines_oe ? data_lines_out : mdl_q;
  bbs_host #(.REC_CYCLES(REC)) uut (.clock(clock), .rstn(rstn), .req(req),
    .req_wr(req_wr), .req_addr(req_addr), .req_wdata(req_wdata),
    .ready(ready), .done(done), .rdata(rdata),
    .battery_low_flag(battery_low_flag), .power_fail(power_fail),
    .chip_sel_n(chip_sel_n), .gate_n(gate_n), .strobe_n(strobe_n),
    .mem_addr(mem_addr), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .data_lines_in(bus));
  bbs_sram_model mdl (.pwr_up(rstn), .bat_low_in(bat_low),
    .pf(power_fail), .cs_n(chip_sel_n), .g_n(gate_n), .w_n(strobe_n),
    .a(mem_addr), .d(bus), .q(mdl_q));
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic logic [7:0] pre(input logic [14:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : pre
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  // Bounded wait for the idle level; returns cycles spent
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    check({15'h0000, ready}, 16'h0001);
  endtask : wait_ready
  // Request held up to the taking edge; lat counts edges to done
  task automatic access(input logic wr, input logic [14:0] a,
                        input logic [7:0] d, output int lat);
    int n;
    wait_ready(n);
    req = 1'b1;
    req_wr = wr;
    req_addr = a;
    req_wdata = d;
    step(1);
    req = 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 20)
    begin
      step(1);
      lat++;
    end
  endtask : access
  task automatic rd_exp(input logic [14:0] a, input logic [7:0] e);
    int lat;
    access(1'b0, a, 8'h00, lat);
    check(16'(lat), 16'h0008);
    check({8'h00, rdata}, {8'h00, e});
  endtask : rd_exp
  task automatic wr_rd(input logic [14:0] a, input logic [7:0] d);
    int lat;
    access(1'b1, a, d, lat);
    check(16'(lat), 16'h0003);
    rd_exp(a, d);
  endtask : wr_rd
  // Power-up: select held off while in reset, ready only after recovery, then battery verdict
  task automatic do_reset(input logic bat);
    int n;
    rstn = 1'b0;
    bat_low = bat;
    step(16);
    check({15'h0000, chip_sel_n}, 16'h0001);
    rstn = 1'b1;
    wait_ready(n);
    check(16'(n > REC), 16'h0001);
    check({15'h0000, battery_low_flag}, {15'h0000, bat});
  endtask : do_reset
  // Back-to-back accesses at the address extremes and mid-range (15'h4000), neighbours kept
  task automatic t_basic;
    wr_rd(15'h0001, 8'ha5);
    wr_rd(15'h7fff, 8'h3c);
    wr_rd(15'h4000, 8'hff);
    rd_exp(15'h7ffe, pre(15'h7ffe));
    rd_exp(CHECK_ADDR, pre(CHECK_ADDR));
  endtask : t_basic
  // Weak battery swallows the check write; later writes go through
  task automatic t_batt;
    do_reset(1'b1);
    rd_exp(CHECK_ADDR, pre(CHECK_ADDR));
    wr_rd(15'h0100, 8'h00);
    do_reset(1'b0);
  endtask : t_batt
  // Supply fails in mid-write: pins go quiet, other bytes survive
  task automatic t_pf;
    int n;
    wait_ready(n);
    req = 1'b1;
    req_wr = 1'b1;
    req_addr = 15'h0200;
    req_wdata = 8'h11;
    step(1);
    req = 1'b0;
    power_fail = 1'b1;
    step(8);
    check({13'h0000, chip_sel_n, strobe_n, data_lines_oe}, 16'h0006);
    check({15'h0000, ready}, 16'h0000);
    power_fail = 1'b0;
    wait_ready(n);
    check(16'(n > REC), 16'h0001);
    rd_exp(15'h0201, pre(15'h0201));
    wr_rd(15'h0200, 8'h77);
  endtask : t_pf
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial
  begin
    failures = 0;
    tests_run = 0;
    rstn = 1'b0;
    req = 1'b0;
    req_wr = 1'b0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    power_fail = 1'b0;
    bat_low = 1'b0;
    do_reset(1'b0);
    t_basic;
    t_batt;
    t_pf;
    end_of_test;
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #400000;
    failures++;
    end_of_test;
  end
endmodule : tb_top
